/* shared/align_cfg.svh */
`ifndef ALIGN_CFG_SVH
`define ALIGN_CFG_SVH

`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_MASK        4'h8
`define REG_BYTE_ADDR   4'hc

`define CTRL_ENABLE_BIT 0
`define CTRL_RESET      1'b1
`define MASK_RESET      3'h0

`define EV_COUNT        3
`define EV_LOAD         0
`define EV_STORE        1
`define EV_OVERFLOW     2

`define LANES_ALL_OFF   4'hf
`define LANES_ALL_ON    4'h0
`define REG_COUNT       32

`endif

/* shared/align_pkg.sv */
`include "align_cfg.svh"
package align_pkg;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_ADDR_GEN,
        OP_LOAD_WORD,
        OP_LOAD_ALIGN,
        OP_STORE_ALIGN,
        OP_STORE_DATA
    } op_kind_t;

    typedef struct packed {
        logic        valid;
        op_kind_t    kind;
        logic [1:0]  size_field;
        logic        sign_select;
        logic        alignment_bypass;
        logic [4:0]  dest_reg_select;
        logic [4:0]  src_reg_select;
        logic [31:0] operand;
        logic        condition_output_in;
    } op_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  byte_write_enable_n;
        logic        store_strobe;
        logic        condition_output;
        logic [31:0] address;
        logic        address_strobe;
    } mem_side_t;

    typedef struct packed {
        op_req_t                pipe;
        mem_side_t              mem;
        logic [1:0]             byte_addr;
        logic                   enable;
        logic [`EV_COUNT-1:0]   status;
        logic [`EV_COUNT-1:0]   mask;
        logic                   irq;
        logic                   waitrequest;
        logic [31:0]            readdata;
    } lsu_state_t;

    typedef struct packed {
        logic [`REG_COUNT-1:0][31:0] word;
        logic [31:0]                 rd_a;
        logic [31:0]                 rd_b;
    } regs_t;

endpackage

/* rtl/reg_file.sv */
`timescale 1ns/1ns
module reg_file (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Read ports, data one cycle after select
    input  wire logic [4:0]  rd_a_sel,
    input  wire logic [4:0]  rd_b_sel,
    output logic      [31:0] rd_a_q,
    output logic      [31:0] rd_b_q,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_sel,
    input  wire logic [31:0] wr_data
);
    align_pkg::regs_t q;
    align_pkg::regs_t d;

    // Reads see the old word when the same word is written in that cycle
    always_comb begin
        d = q;
        d.rd_a = q.word[rd_a_sel];
        d.rd_b = q.word[rd_b_sel];
        if (wr_en) begin
            d.word[wr_sel] = wr_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_a_q = q.rd_a;
    assign rd_b_q = q.rd_b;
endmodule

/* rtl/byte_align_load_store_unit.sv */
`timescale 1ns/1ns
`include "align_cfg.svh"
module byte_align_load_store_unit (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Operation from instruction decode
    input  wire align_pkg::op_req_t     op_in,
    // Memory side
    output align_pkg::mem_side_t        mem_out,
    // Avalon-MM slave
    input  wire logic [3:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // Interrupt
    output logic                        irq
);
    align_pkg::lsu_state_t q;
    align_pkg::lsu_state_t d;

    logic [31:0]            rd_src;
    logic [31:0]            rd_dest;
    logic                   wb_en;
    logic [31:0]            wb_data;
    logic [`EV_COUNT-1:0]   events;
    logic [31:0]            fmask;
    logic [31:0]            ld_shift;
    logic                   ld_top;
    logic [31:0]            ld_res;
    logic                   st_top;
    logic [31:0]            st_data;
    logic                   st_ovf;
    logic [3:0]             st_lanes_n;
    logic [31:0]            rd_mux;
    logic [`EV_COUNT-1:0]   rd_clear;

    // Mask covering the low size+1 bytes
    function automatic logic [31:0] byte_mask(input logic [1:0] size);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            if (i <= int'(size)) begin
                m[i*8 +: 8] = 8'hff;
            end
        end
        return m;
    endfunction

    // Active-low enables for lanes ofs through ofs+size
    function automatic logic [3:0] lanes_n(input logic [1:0] size, input logic [1:0] ofs);
        logic [3:0] l;
        l = `LANES_ALL_OFF;
        for (int i = 0; i < 4; i++) begin
            if (i >= int'(ofs) && i <= int'(ofs) + int'(size)) begin
                l[i] = 1'b0;
            end
        end
        return l;
    endfunction

    reg_file u_regs (
        .clk      (clk),
        .reset    (reset),
        .rd_a_sel (op_in.src_reg_select),
        .rd_b_sel (op_in.dest_reg_select),
        .rd_a_q   (rd_src),
        .rd_b_q   (rd_dest),
        .wr_en    (wb_en),
        .wr_sel   (q.pipe.dest_reg_select),
        .wr_data  (wb_data)
    );

    // Load path: shift field down, then widen
    assign fmask    = byte_mask(q.pipe.size_field);
    assign ld_shift = rd_src >> {q.byte_addr, 3'b000};
    assign ld_top   = ld_shift[{q.pipe.size_field, 3'b111}];
    assign ld_res   = (ld_shift & fmask) |
                      (~fmask & {32{q.pipe.sign_select & ld_top}});

    // Store path: truncate, shift up, check lost bits
    assign st_top     = rd_src[{q.pipe.size_field, 3'b111}];
    assign st_data    = (rd_src & fmask) << {q.byte_addr, 3'b000};
    assign st_ovf     = q.pipe.sign_select ?
                        ((rd_src & ~fmask) != (~fmask & {32{st_top}})) :
                        ((rd_src & ~fmask) != 32'h0);
    assign st_lanes_n = lanes_n(q.pipe.size_field, q.byte_addr);

    always_comb begin
        case (avs_address)
            `REG_CTRL:      rd_mux = {31'h0, q.enable};
            `REG_STATUS:    rd_mux = {29'h0, q.status};
            `REG_MASK:      rd_mux = {29'h0, q.mask};
            `REG_BYTE_ADDR: rd_mux = q.mem.address;
            default:        rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        d        = q;
        wb_en    = 1'b0;
        wb_data  = 32'h0;
        events   = '0;
        rd_clear = '0;

        d.pipe = op_in;
        if (!q.enable) begin
            d.pipe.valid = 1'b0;
        end

        d.mem.store_strobe        = 1'b0;
        d.mem.address_strobe      = 1'b0;
        d.mem.byte_write_enable_n = `LANES_ALL_OFF;

        if (q.pipe.valid) begin
            case (q.pipe.kind)
                align_pkg::OP_ADDR_GEN: begin
                    d.byte_addr          = q.pipe.operand[1:0];
                    d.mem.address        = q.pipe.operand;
                    d.mem.address_strobe = 1'b1;
                end
                align_pkg::OP_LOAD_WORD: begin
                    wb_en   = 1'b1;
                    wb_data = q.pipe.operand;
                end
                align_pkg::OP_LOAD_ALIGN: begin
                    // Condition and address outputs keep their values
                    wb_en            = 1'b1;
                    wb_data          = ld_res;
                    events[`EV_LOAD] = 1'b1;
                end
                align_pkg::OP_STORE_ALIGN: begin
                    d.mem.store_strobe        = 1'b1;
                    d.mem.byte_write_enable_n = st_lanes_n;
                    events[`EV_STORE]         = 1'b1;
                    if (q.pipe.alignment_bypass) begin
                        d.mem.data             = rd_dest;
                        d.mem.condition_output = 1'b0;
                    end else begin
                        d.mem.data             = st_data;
                        d.mem.condition_output = st_ovf;
                        events[`EV_OVERFLOW]   = st_ovf;
                    end
                end
                align_pkg::OP_STORE_DATA: begin
                    d.mem.data                = q.pipe.operand;
                    d.mem.byte_write_enable_n = `LANES_ALL_ON;
                    d.mem.store_strobe        = 1'b1;
                    d.mem.condition_output    = q.pipe.condition_output_in;
                    events[`EV_STORE]         = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Bus slave: one wait cycle, answer in the next
        if (!q.waitrequest) begin
            d.waitrequest = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
                case (avs_address)
                    `REG_CTRL: d.enable = avs_writedata[`CTRL_ENABLE_BIT];
                    `REG_MASK: d.mask   = avs_writedata[`EV_COUNT-1:0];
                    default: begin
                    end
                endcase
            end
            if (avs_read && avs_address == `REG_STATUS) begin
                rd_clear = q.readdata[`EV_COUNT-1:0];
            end
        end else if (avs_read || avs_write) begin
            d.waitrequest = 1'b0;
            d.readdata    = avs_read ? rd_mux : 32'h0;
        end

        // Only reported bits clear; a new event always wins
        d.status = (q.status & ~rd_clear) | events;
        d.irq    = |(d.status & d.mask);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q                              <= '0;
            q.enable                       <= `CTRL_RESET;
            q.mask                         <= `MASK_RESET;
            q.waitrequest                  <= 1'b1;
            q.mem.byte_write_enable_n      <= `LANES_ALL_OFF;
        end else begin
            q <= d;
        end
    end

    assign mem_out         = q.mem;
    assign avs_readdata    = q.readdata;
    assign avs_waitrequest = q.waitrequest;
    assign irq             = q.irq;

    sequence s_load_in_pipe;
        q.pipe.valid && q.pipe.kind == align_pkg::OP_LOAD_ALIGN;
    endsequence

    sequence s_store_in_pipe;
        q.pipe.valid && q.pipe.kind == align_pkg::OP_STORE_ALIGN;
    endsequence

    sequence s_store_data_in_pipe;
        q.pipe.valid && q.pipe.kind == align_pkg::OP_STORE_DATA;
    endsequence

    sequence s_store_issue;
        op_in.valid && q.enable && op_in.kind == align_pkg::OP_STORE_ALIGN &&
        (int'(op_in.size_field) + int'(q.byte_addr) <= 3);
    endsequence

    load_word_pass_a: assert property (@(posedge clk) disable iff (reset)
        s_load_in_pipe and (q.pipe.size_field == 2'h3 && q.byte_addr == 2'h0)
        |-> wb_en && wb_data == rd_src)
        else $error("word load not passed whole");

    load_offset_a: assert property (@(posedge clk) disable iff (reset)
        s_load_in_pipe and (q.pipe.size_field == 2'h0)
        |-> wb_data[7:0] == rd_src[{q.byte_addr, 3'b000} +: 8])
        else $error("load byte taken from wrong lane");

    load_extend_a: assert property (@(posedge clk) disable iff (reset)
        s_load_in_pipe and (q.pipe.size_field == 2'h1)
        |-> wb_data[31:16] == {16{q.pipe.sign_select & wb_data[15]}})
        else $error("halfword load widened wrongly");

    load_condition_output_hold_a: assert property (@(posedge clk) disable iff (reset)
        s_load_in_pipe |=> $stable(mem_out.condition_output) && !mem_out.address_strobe)
        else $error("load disturbed condition or address");

    bypass_store_a: assert property (@(posedge clk) disable iff (reset)
        s_store_in_pipe and q.pipe.alignment_bypass |=> mem_out.data == $past(rd_dest))
        else $error("bypass store altered data");

    store_zero_fill_a: assert property (@(posedge clk) disable iff (reset)
        s_store_in_pipe and !q.pipe.alignment_bypass and (q.pipe.size_field == 2'h0)
        |=> mem_out.data == ({24'h0, $past(rd_src[7:0])} << {$past(q.byte_addr), 3'b000}))
        else $error("aligned byte store data wrong");

    store_lanes_a: assert property (@(posedge clk) disable iff (reset)
        s_store_issue |-> ##2 mem_out.store_strobe &&
        mem_out.byte_write_enable_n ==
        ~(4'((5'h2 << $past(op_in.size_field, 2)) - 5'h1) << $past(q.byte_addr, 1)))
        else $error("byte enables do not match size and offset");

    idle_lanes_off_a: assert property (@(posedge clk) disable iff (reset)
        !mem_out.store_strobe |-> mem_out.byte_write_enable_n == `LANES_ALL_OFF)
        else $error("byte enable asserted with no store");

    store_overflow_a: assert property (@(posedge clk) disable iff (reset)
        s_store_in_pipe and !q.pipe.alignment_bypass and !q.pipe.sign_select and
        (q.pipe.size_field == 2'h0) and (rd_src[31:8] != 24'h0)
        |=> mem_out.condition_output && q.status[`EV_OVERFLOW])
        else $error("truncation not flagged");

    addr_update_a: assert property (@(posedge clk) disable iff (reset)
        q.pipe.valid && q.pipe.kind == align_pkg::OP_ADDR_GEN
        |=> q.byte_addr == $past(q.pipe.operand[1:0]) && mem_out.address_strobe)
        else $error("byte address not updated");

    store_data_condition_output_a: assert property (@(posedge clk) disable iff (reset)
        s_store_data_in_pipe |=> mem_out.condition_output == $past(q.pipe.condition_output_in))
        else $error("companion condition altered");

    store_data_all_a: assert property (@(posedge clk) disable iff (reset)
        s_store_data_in_pipe
        |=> mem_out.byte_write_enable_n == `LANES_ALL_ON && mem_out.data == $past(q.pipe.operand))
        else $error("store data not driven on all lanes");

    sequence s_bus_request;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_status_read;
        avs_read && !avs_waitrequest && avs_address == `REG_STATUS;
    endsequence

    load_byte_extend_a: assert property (@(posedge clk) disable iff (reset)
        s_load_in_pipe and (q.pipe.size_field == 2'h0)
        |-> wb_data[31:8] == {24{q.pipe.sign_select & wb_data[7]}})
        else $error("byte load widened wrongly");

    signed_overflow_a: assert property (@(posedge clk) disable iff (reset)
        s_store_in_pipe and !q.pipe.alignment_bypass and q.pipe.sign_select and
        (q.pipe.size_field == 2'h1)
        |=> mem_out.condition_output == ($past(rd_src[31:16]) != {16{$past(rd_src[15])}}))
        else $error("signed halfword truncation misjudged");

    bus_answer_a: assert property (@(posedge clk) disable iff (reset)
        s_bus_request |=> !avs_waitrequest)
        else $error("bus request not answered");

    wait_single_a: assert property (@(posedge clk) disable iff (reset)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    status_keep_a: assert property (@(posedge clk) disable iff (reset)
        q.status[`EV_STORE] && !(avs_read && !avs_waitrequest && avs_address == `REG_STATUS)
        |=> q.status[`EV_STORE])
        else $error("sticky status bit lost");

    status_clear_a: assert property (@(posedge clk) disable iff (reset)
        s_status_read and (avs_readdata[`EV_STORE] && !events[`EV_STORE])
        |=> !q.status[`EV_STORE])
        else $error("reported status bit not cleared");

    irq_level_a: assert property (@(posedge clk) disable iff (reset)
        irq == |(q.status & q.mask))
        else $error("interrupt level disagrees with status and mask");
endmodule

/* bench/ext_mem.sv */
`timescale 1ns/1ns
module ext_mem (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Bus from the unit
    input  wire align_pkg::mem_side_t bus,
    // Inspection port
    input  wire logic [5:0]           rd_idx,
    output logic      [31:0]          rd_word
);
    logic [63:0][31:0] word_q;

    assign rd_word = word_q[rd_idx];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            word_q <= {64{32'h5a5a_5a5a}};
        end else if (bus.store_strobe) begin
            for (int i = 0; i < 4; i++) begin
                if (!bus.byte_write_enable_n[i]) begin
                    word_q[bus.address[7:2]][8*i+:8] <= bus.data[8*i+:8];
                end
            end
        end
    end
endmodule

/* bench/byte_align_load_store_unit_tb_top.sv */
`timescale 1ns/1ns
module byte_align_load_store_unit_tb_top;
    logic                 clk;
    logic                 reset;
    align_pkg::op_req_t   op_in;
    align_pkg::mem_side_t mem_out;
    logic [3:0]           avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [3:0]           avs_byteenable;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic                 irq;
    logic [5:0]           rd_idx;
    logic [31:0]          rd_word;
    logic [31:0]          rd;
    int                   fail_count;
    int                   total_checks;
    int                   cycles;

    byte_align_load_store_unit u_byte_align_load_store_unit (
        .clk(clk), .reset(reset), .op_in(op_in), .mem_out(mem_out),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

    ext_mem u_ext_mem (
        .clk(clk), .reset(reset), .bus(mem_out), .rd_idx(rd_idx), .rd_word(rd_word));

    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) check(1'b1, 1'b0, "bus timeout");
    endtask

    task automatic send(input align_pkg::op_kind_t k, input logic [1:0] sz, input logic sg,
                        input logic byp, input logic [4:0] dst, input logic [4:0] src,
                        input logic [31:0] opd, input logic ci);
        @(posedge clk);
        op_in <= '{1'b1, k, sz, sg, byp, dst, src, opd, ci};
        @(posedge clk);
        op_in.valid <= 1'b0;
    endtask

    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // Zero or sign extension of the low sz+1 bytes
    function automatic logic [31:0] ext(input logic [31:0] v, input int sz, input logic sg);
        logic [31:0] m;
        m = (sz == 3) ? 32'hffff_ffff : ((32'h1 << (8 * (sz + 1))) - 32'h1);
        ext = v & m;
        if (sg && v[8*sz+7]) ext = v | ~m;
    endfunction

    task automatic test_store_align();
        logic [31:0] src;
        logic [31:0] dat;
        logic [31:0] ln;
        logic [3:0]  en_n;
        logic        ovf;
        int k;
        k = 0;
        for (int sg = 0; sg < 2; sg++) begin
            for (int sz = 0; sz < 4; sz++) begin
                for (int off = 0; off + sz < 4; off++) begin
                    src = k[0] ? 32'hffff_8085 : 32'h0000_0081;
                    dat = ext(src, sz, 1'b0) << (8 * off);
                    ln = ext(32'hffff_ffff, sz, 1'b0) << (8 * off);
                    en_n = ~{ln[24], ln[16], ln[8], ln[0]};
                    ovf = src !== ext(src, sz, sg[0]);
                    send(align_pkg::OP_ADDR_GEN, 2'h0, 1'b0, 1'b0, 5'h0, 5'h0, 4 * k + off, 1'b0);
                    send(align_pkg::OP_LOAD_WORD, 2'h0, 1'b0, 1'b0, 5'h3, 5'h0, src, 1'b0);
                    send(align_pkg::OP_STORE_ALIGN, sz[1:0], sg[0], 1'b0, 5'h0, 5'h3, 32'h0, 1'b0);
                    rd_idx <= 6'(k);
                    settle();
                    check(mem_out.data, dat, "store data");
                    check(mem_out.byte_write_enable_n, en_n, "lanes");
                    check(mem_out.condition_output, ovf, "condition_output");
                    settle();
                    check(mem_out.byte_write_enable_n, 4'hf, "lanes off");
                    check(rd_word, (32'h5a5a_5a5a & ~ln) | dat, "memory");
                    k++;
                end
            end
        end
        $display("Test store_align done");
    endtask

    task automatic test_load_align();
        logic [31:0] w;
        logic [31:0] base;
        logic [31:0] want;
        w = 32'h8e7c_f1a3;
        send(align_pkg::OP_LOAD_WORD, 2'h0, 1'b0, 1'b0, 5'h1, 5'h0, w, 1'b0);
        for (int sg = 0; sg < 2; sg++) begin
            for (int sz = 0; sz < 4; sz++) begin
                for (int off = 0; off + sz < 4; off++) begin
                    base = 32'h100 + off;
                    want = ext(w >> (8 * off), sz, sg[0]);
                    send(align_pkg::OP_ADDR_GEN, 2'h0, 1'b0, 1'b0, 5'h0, 5'h0, base, 1'b0);
                    settle();
                    check(mem_out.address_strobe, 1'b1, "addr strobe");
                    send(align_pkg::OP_LOAD_ALIGN, sz[1:0], sg[0], 1'b0, 5'h2, 5'h1, 32'h0, 1'b0);
                    settle();
                    check(mem_out.address, base, "addr held");
                    check(mem_out.store_strobe, 1'b0, "no store");
                    send(align_pkg::OP_STORE_ALIGN, 2'h0, 1'b0, 1'b1, 5'h2, 5'h1, 32'h0, 1'b0);
                    settle();
                    check(mem_out.data, want, "load");
                    check(mem_out.condition_output, 1'b0, "bypass condition_output");
                end
            end
        end
        bus(1'b0, 4'hc, 32'h0, rd);
        check(rd, 32'h100, "byte addr reg");
        bus(1'b0, 4'h4, 32'h0, rd);
        check(rd[1:0], 2'h3, "load status");
        $display("Test load_align done");
    endtask

    task automatic test_store_data_irq();
        for (int c = 0; c < 2; c++) begin
            send(align_pkg::OP_STORE_DATA, 2'h0, 1'b0, 1'b0, 5'h0, 5'h0, 32'hc0de_0000 + c, c[0]);
            settle();
            check(mem_out.data, 32'hc0de_0000 + c, "store data op");
            check(mem_out.byte_write_enable_n, 4'h0, "all lanes");
            check(mem_out.condition_output, c[0], "condition_output pass");
        end
        bus(1'b0, 4'h0, 32'h0, rd);
        check(rd, 32'h1, "ctrl reset");
        bus(1'b0, 4'h1, 32'h0, rd);
        check(rd, 32'h0, "unmapped");
        bus(1'b0, 4'h4, 32'h0, rd);
        bus(1'b1, 4'h8, 32'h4, rd);
        send(align_pkg::OP_LOAD_WORD, 2'h0, 1'b0, 1'b0, 5'h3, 5'h0, 32'h105, 1'b0);
        send(align_pkg::OP_ADDR_GEN, 2'h0, 1'b0, 1'b0, 5'h0, 5'h0, 32'h0, 1'b0);
        send(align_pkg::OP_STORE_DATA, 2'h0, 1'b0, 1'b0, 5'h0, 5'h0, 32'h0, 1'b0);
        repeat (3) settle();
        check(irq, 1'b0, "masked irq");
        send(align_pkg::OP_STORE_ALIGN, 2'h0, 1'b0, 1'b0, 5'h0, 5'h3, 32'h0, 1'b0);
        repeat (3) settle();
        check(irq, 1'b1, "irq on");
        bus(1'b0, 4'h4, 32'h0, rd);
        check(rd, 32'h6, "status");
        repeat (2) settle();
        check(irq, 1'b0, "irq cleared");
        avs_byteenable <= 4'he;
        bus(1'b1, 4'h0, 32'h0, rd);
        avs_byteenable <= 4'hf;
        bus(1'b0, 4'h0, 32'h0, rd);
        check(rd, 32'h1, "write without lane 0 ignored");
        bus(1'b1, 4'h0, 32'h0, rd);
        send(align_pkg::OP_STORE_DATA, 2'h0, 1'b0, 1'b0, 5'h0, 5'h0, 32'h0, 1'b0);
        repeat (3) begin
            settle();
            check(mem_out.store_strobe, 1'b0, "disabled");
        end
        bus(1'b1, 4'h0, 32'h1, rd);
        $display("Test store_data_irq done");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("ERROR %0t run timed out", $time);
            close_out();
        end
    end

    initial begin
        reset = 1'b1;
        op_in = '0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        rd_idx = 6'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        test_store_align();
        test_load_align();
        test_store_data_irq();
        close_out();
    end
endmodule
